// >>> dv/adc_model.sv
`timescale 1ns/1ps
module adc_model #(parameter integer LAT = 20) (
   input  wire        core_clk,
   input  wire        rst_b,
   input  wire        adc_start,
   input  wire [10:0] temp_code,
   output reg         adc_done = 1'b0,
   output reg  [10:0] adc_result
);
   integer cnt = 0;
   // answers a start after LAT cycles; result is scrambled outside the pulse
   always @(posedge core_clk) begin
      adc_done <= rst_b && cnt == 1;
      adc_result <= (cnt == 1) ? temp_code : ~temp_code;
      cnt <= !rst_b ? 0 : adc_start ? LAT : (cnt > 0 ? cnt - 1 : 0);
   end
endmodule // adc_model

// >>> dv/thermal_watchdog_core_checker.sv
`timescale 1ns/1ps
module thermal_watchdog_core_checker #(parameter integer CONV_CYCLES = 200) (
   input wire        core_clk,
   input wire        rst_b,
   input wire [1:0]  reg_addr,
   input wire [15:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [15:0] reg_rdata,
   input wire        adc_done,
   input wire        adc_start,
   input wire        overtemp_alert_out
);
   reg [7:0]  conf;
   reg [31:0] idle;
   // shadow config; idle counts cycles since a start and is parked in shutdown
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) {conf, idle} <= 40'h0;
      else begin
         if (reg_wr && reg_addr == 2'h1) conf <= reg_wdata[7:0];
         idle <= (adc_start || conf[0]) ? 32'h0 : idle + 32'h1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_lim; reg_wr && reg_addr == 2'h3 ##1 reg_rd && reg_addr == 2'h3; endsequence
   property p_per; idle <= CONV_CYCLES; endproperty
   a_per: assert property (p_per) else $error("period");
   property p_tmp; reg_rd && reg_addr == 2'h0 |=> reg_rdata[4:0] == 5'h00; endproperty
   a_tmp: assert property (p_tmp) else $error("temp bits");
   property p_off; conf[0] && !reg_wr |=> !adc_start; endproperty
   a_off: assert property (p_off) else $error("start in shutdown");
   property p_wake; $fell(conf[0]) |-> ##[0:1] adc_start; endproperty
   a_wake: assert property (p_wake) else $error("no wake start");
   property p_lim; s_lim |=> reg_rdata[15:7] == $past(reg_wdata[15:7], 2); endproperty
   a_lim: assert property (p_lim) else $error("limit readback");
   property p_hold; !conf[1] && !adc_done && !reg_wr ##1 !adc_done && !reg_wr
      |=> $stable(overtemp_alert_out); endproperty
   a_hold: assert property (p_hold) else $error("alert moved");
   property p_clr; conf[1] && reg_rd && !adc_done && !reg_wr ##1 !adc_done && !reg_wr
      |=> overtemp_alert_out != conf[2]; endproperty
   a_clr: assert property (p_clr) else $error("alert kept");
   property p_rst; $rose(rst_b) |-> overtemp_alert_out ##1 adc_start; endproperty
   a_rst: assert property (p_rst) else $error("power-up");
endmodule // thermal_watchdog_core_checker
bind thermal_watchdog_core thermal_watchdog_core_checker #(.CONV_CYCLES(CONV_CYCLES)) chk_i (
   .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_done(adc_done),
   .adc_start(adc_start), .overtemp_alert_out(overtemp_alert_out));

// >>> dv/thermal_watchdog_core_tb.sv
`timescale 1ns/1ps
module thermal_watchdog_core_tb;
   reg         core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   reg  [1:0]  reg_addr = 2'h0;
   reg  [15:0] reg_wdata = 16'h0, rv;
   reg  [10:0] temp = 11'h230;
   wire [15:0] reg_rdata;
   wire [10:0] adc_result;
   wire        adc_done, adc_start, overtemp_alert_out;
   integer     error_cnt = 0, checks_done = 0, i;
   thermal_watchdog_core #(.CONV_CYCLES(200)) dut (.core_clk(core_clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .adc_done(adc_done), .adc_result(adc_result),
      .adc_start(adc_start), .conv_busy(), .overtemp_alert_out(overtemp_alert_out));
   adc_model conv (.core_clk(core_clk), .rst_b(rst_b), .adc_start(adc_start),
      .temp_code(temp), .adc_done(adc_done), .adc_result(adc_result));
   initial forever #12.5 core_clk = ~core_clk;
   task chk(input [15:0] s, input [15:0] e);
      begin
         checks_done = checks_done + 1;
         if (s !== e) begin
            error_cnt = error_cnt + 1;
            $display("FAIL %0t: %h not %h", $time, s, e);
         end
      end
   endtask
   // callers enter just after an edge, so strobes can run back to back;
   // read data is taken in the cycle after the strobe
   task wr(input [1:0] a, input [15:0] d);
      begin
         {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
         @(posedge core_clk) reg_wr <= 1'b0;
      end
   endtask
   task rd(input [1:0] a);
      begin
         {reg_addr, reg_rd} <= {a, 1'b1};
         @(posedge core_clk) reg_rd <= 1'b0;
         #1 rv = reg_rdata;
      end
   endtask
   // wait n results, then let the two-cycle pin latency pass before looking
   task al(input integer n, input e);
      begin
         repeat (n) @(posedge adc_done);
         repeat (3) @(posedge core_clk);
         #1 chk({15'h0, overtemp_alert_out}, {15'h0, e});
      end
   endtask
   task t_pwr;
      begin
         al(1, 1'b1);
         rd(2'h2); chk(rv, 16'h4b00);
         rd(2'h3); chk(rv, 16'h5000);
         rd(2'h0); chk(rv, 16'h4600);
         $display("power-up test done");
      end
   endtask
   // comparator mode: settings 0..3 need 1, 2, 4, 6 hot results in a row
   task t_queue;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            wr(2'h1, {11'h0, i[1:0], 3'h0});
            temp <= 11'h288;
            al((i == 0) ? 0 : 2 * i - 1, 1'b1);
            al(1, 1'b0);
            rd(2'h0); chk(rv, 16'h5100);
            temp <= 11'h230;
            al(7, 1'b1);
         end
         $display("queue test done");
      end
   endtask
   task t_int;
      begin
         wr(2'h3, 16'h4800);
         rd(2'h3); chk(rv, 16'h4800);
         wr(2'h1, 16'h0006);
         temp <= 11'h268;
         al(2, 1'b1);
         rd(2'h2); al(0, 1'b0);
         temp <= 11'h230;
         al(1, 1'b1);
         rd(2'h1); al(0, 1'b0);
         $display("interrupt test done");
      end
   endtask
   task t_shut;
      begin
         wr(2'h1, 16'h0001);
         temp <= 11'h288;
         repeat (500) @(posedge core_clk);
         rd(2'h0); chk(rv, 16'h4600);
         wr(2'h1, 16'h0000);
         al(1, 1'b0);
         wr(2'h1, 16'h0001);
         repeat (300) @(posedge core_clk);
         #1 chk({15'h0, overtemp_alert_out}, 16'h0000);
         rd(2'h0); chk(rv, 16'h5100);
         $display("shutdown test done");
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d errors %0d", checks_done, error_cnt);
         if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      t_pwr;
      t_queue;
      t_int;
      t_shut;
      end_of_test;
   end
   // hang guard, several times the expected run
   initial begin
      #1000000 error_cnt = error_cnt + 1;
      end_of_test;
   end
endmodule // thermal_watchdog_core_tb

// >>> rtl/thermal_watchdog_core.v
`timescale 1ns/1ps
// Summary of operation
// - in normal mode convert every 100 ms and load the result when done
// - result is 11-bit two's complement, 0.125 degC per step
// - reading the result never disturbs or restarts a running conversion
// - shutdown stops conversion, keeps last result, bus stays active
// - configuration bit B0 selects normal or shutdown
// - a conversion starts at power-up and on leaving shutdown
// - after each normal conversion compare with both limits, update output
// - limits are 9-bit signed read/write; compare uses result's top 9 bits
// - configuration bit B1 selects comparator or interrupt mode
// - comparator: assert above threshold, deassert below hysteresis
// - comparator: reads and shutdown leave the output level alone
// - interrupt: first event is threshold trip, held until any register read
// - interrupt: events alternate threshold then hysteresis, each read-cleared
// - output asserts only after programmed consecutive faults, bits B3 and B4
// - configuration bit B2 selects output active level
// - reset: normal mode, 80 degC, 75 degC, active low, one fault
// - fault count settings 0..3 need 1, 2, 4, 6 faults
// - polarity bit one is active high, zero active low by default
// - mode bit one is interrupt, zero comparator by default
// - operation bit one is shutdown, zero normal by default
`include "thermal_watchdog_consts.vh"

module thermal_watchdog_core #(
   parameter integer CONV_CYCLES = `CONV_CYCLES
) (
   input  wire        core_clk,
   input  wire        rst_b,
   input  wire [1:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   input  wire        adc_done,
   input  wire [10:0] adc_result,
   output reg         adc_start,
   output reg         conv_busy,
   output reg         overtemp_alert_out
);

   // fault count setting to required consecutive faults
   function [2:0] faults_needed;
      input [1:0] fault_count_setting;
      begin
         case (fault_count_setting)
            2'h0:    faults_needed = 3'h1;
            2'h1:    faults_needed = 3'h2;
            2'h2:    faults_needed = 3'h4;
            2'h3:    faults_needed = 3'h6;
            default: faults_needed = 3'h1;
         endcase
      end
   endfunction

   reg  [7:0]  conf;
   reg  [8:0]  overt_limit;
   reg  [8:0]  hyst_limit;
   reg  [10:0] temp_result;
   reg  [31:0] period_cnt;
   reg         converting;
   reg         start_pending;
   reg         alert_state;
   reg         int_hunt_hyst;
   reg  [2:0]  fault_cnt;
   reg  [2:0]  next_fault_cnt;
   reg         next_alert_state;
   reg         next_int_hunt_hyst;

   // reset limits kept as full words so the 9-bit fields are cut on purpose
   localparam [15:0] OVERT_RST = `OVERT_RESET;
   localparam [15:0] HYST_RST  = `HYST_RESET;

   wire        shutdown   = conf[`CONF_SHUTDOWN];
   wire        int_mode   = conf[`CONF_INT_MODE];
   wire        pol_high   = conf[`CONF_POLARITY];
   wire [1:0]  fault_count_setting = conf[`CONF_QUEUE_HI:`CONF_QUEUE_LO];
   wire [2:0]  need       = faults_needed(fault_count_setting);

   // compare against the new result's top nine bits, signed
   wire signed [8:0] new_top = adc_result[10:2];
   wire        above      = new_top > $signed(overt_limit);
   wire        below      = new_top < $signed(hyst_limit);
   // which fault is being watched depends on mode and current state
   wire        watch_hyst = int_mode ? int_hunt_hyst : alert_state;
   wire        fault      = watch_hyst ? below : above;
   wire        conv_end   = converting & adc_done & ~shutdown;
   wire        limit_hit  = conv_end & fault & (fault_cnt + 3'h1 >= need);

   // conversion scheduler; restarts after shutdown, counts the period
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         period_cnt    <= 32'h0;
         converting    <= 1'b0;
         start_pending <= 1'b1;
         adc_start     <= 1'b0;
         conv_busy     <= 1'b0;
      end else begin
         adc_start <= 1'b0;
         if (shutdown) begin
            converting    <= 1'b0;
            start_pending <= 1'b1;
            period_cnt    <= 32'h0;
            conv_busy     <= 1'b0;
         end else if (start_pending || period_cnt == CONV_CYCLES - 1) begin
            start_pending <= 1'b0;
            period_cnt    <= 32'h0;
            converting    <= 1'b1;
            adc_start     <= 1'b1;
            conv_busy     <= 1'b1;
         end else begin
            period_cnt <= period_cnt + 32'h1;
            if (conv_end) begin
               converting <= 1'b0;
               conv_busy  <= 1'b0;
            end
         end
      end
   end

   // result register; bus reads do not touch the scheduler
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         temp_result <= 11'h0;
      end else if (conv_end) begin
         temp_result <= adc_result;
      end
   end

   // register writes; reset values give a standalone thermostat
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         conf        <= `CONF_RESET;
         overt_limit <= OVERT_RST[15:7];
         hyst_limit  <= HYST_RST[15:7];
      end else if (reg_wr) begin
         case (reg_addr)
            `REG_CONF:  conf        <= reg_wdata[7:0];
            `REG_HYST:  hyst_limit  <= reg_wdata[15:7];
            `REG_OVERT: overt_limit <= reg_wdata[15:7];
            default:    conf        <= conf;
         endcase
      end
   end

   // read data one cycle after the strobe; temp and limits high-aligned, config in the low byte
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            `REG_TEMP:  reg_rdata <= {temp_result, 5'h0};
            `REG_CONF:  reg_rdata <= {8'h0, conf};
            `REG_HYST:  reg_rdata <= {hyst_limit, 7'h0};
            `REG_OVERT: reg_rdata <= {overt_limit, 7'h0};
            default:    reg_rdata <= 16'h0;
         endcase
      end else begin
         reg_rdata <= 16'h0;
      end
   end

   // next state of the consecutive-fault filter and the alert
   // the counter only moves on a finished conversion, so a read or a
   // shutdown in between never loses or adds a fault
   always @* begin
      next_fault_cnt     = fault_cnt;
      next_alert_state   = alert_state;
      next_int_hunt_hyst = int_hunt_hyst;
      if (conv_end) begin
         if (!fault)
            next_fault_cnt = 3'h0;
         else if (limit_hit)
            next_fault_cnt = 3'h0;
         else
            next_fault_cnt = fault_cnt + 3'h1;
      end
      if (!int_mode) begin
         // comparator: only conversions move it, reads and shutdown do not
         if (limit_hit)
            next_alert_state = ~alert_state;
         next_int_hunt_hyst = 1'b0;
      end else begin
         // interrupt: a trip sets and flips the watched limit; a read
         // clears, but a trip in the same cycle wins over the clear
         if (limit_hit) begin
            next_alert_state   = 1'b1;
            next_int_hunt_hyst = ~int_hunt_hyst;
         end else if (reg_rd) begin
            next_alert_state = 1'b0;
         end
      end
   end

   // alert state registers; a mode change keeps the counters as they are
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         alert_state   <= 1'b0;
         int_hunt_hyst <= 1'b0;
         fault_cnt     <= 3'h0;
      end else begin
         alert_state   <= next_alert_state;
         int_hunt_hyst <= next_int_hunt_hyst;
         fault_cnt     <= next_fault_cnt;
      end
   end

   // pin level from state and polarity
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         overtemp_alert_out <= 1'b1;
      else
         overtemp_alert_out <= pol_high ? alert_state : ~alert_state;
   end

endmodule // thermal_watchdog_core

// >>> shared/thermal_watchdog_consts.vh
`ifndef THERMAL_WATCHDOG_CONSTS_VH
`define THERMAL_WATCHDOG_CONSTS_VH
// register pointer values
`define REG_TEMP          2'h0
`define REG_CONF          2'h1
`define REG_HYST          2'h2
`define REG_OVERT         2'h3
// configuration field positions
`define CONF_SHUTDOWN     0
`define CONF_INT_MODE     1
`define CONF_POLARITY     2
`define CONF_QUEUE_LO     3
`define CONF_QUEUE_HI     4
// reset values
`define CONF_RESET        8'h00
`define OVERT_RESET       16'h5000
`define HYST_RESET        16'h4b00
// timing: conversion period in ms, clock in kHz
`define CONV_PERIOD_MS    100
`define CLK_KHZ           40000
`define CONV_CYCLES       (`CONV_PERIOD_MS * `CLK_KHZ)
`endif
